// file: ampc_map.svh
// Constants for the amplifier control and protection block.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef AMPC_MAP_SVH
`define AMPC_MAP_SVH

// Clock rate in MHz; counts stay inside 32-bit integer arithmetic
`define AMPC_CLK_MHZ         250
// Short-fault retry interval in microseconds
`define AMPC_RETRY_US        220000
`define AMPC_RETRY_CYC       (`AMPC_RETRY_US * `AMPC_CLK_MHZ)
// Soft ramp length in microseconds
`define AMPC_RAMP_US         10000
`define AMPC_RAMP_CYC        (`AMPC_RAMP_US * `AMPC_CLK_MHZ)
// Cycles without an external clock edge before a slave counts it as lost
`define AMPC_EXT_IDLE_MAX    12'hfff
// Ramp level width and full-scale level
`define AMPC_LVL_W           8
`define AMPC_LVL_FULL        8'hff
// Gain codes in dB, single-ended and bridged
`define AMPC_GAIN_SE_0       6'h0e
`define AMPC_GAIN_SE_1       6'h14
`define AMPC_GAIN_SE_2       6'h1a
`define AMPC_GAIN_SE_3       6'h20
`define AMPC_GAIN_BTL_OFS    6'h06
// Interrupt bit positions
`define AMPC_IRQ_SHORT       0
`define AMPC_IRQ_OTEMP       1
`define AMPC_IRQ_UVOLT       2
`define AMPC_IRQ_W           3

`endif

// file: ampc_pkg.sv
// Types for the amplifier control and protection block.
// Assumes nothing beyond the constants header.
package ampc_pkg;
	typedef enum {
		ST_OFF,
		ST_RAMP_UP,
		ST_RUN,
		ST_RAMP_DOWN,
		ST_MUTED,
		ST_SHORT
	} ampc_state_t;
endpackage

// file: ampc_ramp_if.sv
// Interface carrying the soft ramp request and level.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface ampc_ramp_if;
	logic       up;
	logic       down;
	logic       clear;
	logic [7:0] level;
	logic       at_top;
	logic       at_zero;
	modport ctrl (output up, output down, output clear, input level, input at_top, input at_zero);
	modport ramp (input up, input down, input clear, output level, output at_top, output at_zero);
endinterface
`default_nettype wire

// file: ampc_sync.sv
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes the reset given is already synchronous to clk_i on release.
`timescale 1ns/1ps
`default_nettype none
module ampc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule
`default_nettype wire

// file: ampc_ramp.sv
// Soft-start / soft-mute ramp generator.
// Assumes the control side raises up or down as levels.
`timescale 1ns/1ps
`default_nettype none
`include "ampc_map.svh"
module ampc_ramp #(
	parameter int STEP_CYC = `AMPC_RAMP_CYC / 255
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	ampc_ramp_if.ramp rif
);
	localparam int SC = (STEP_CYC < 1) ? 1 : STEP_CYC;
	logic [31:0] div_q;
	logic [7:0]  lvl_q;
	logic        tick;

	assign tick        = (div_q == 32'(SC - 1));
	assign rif.level   = lvl_q;
	assign rif.at_top  = (lvl_q == `AMPC_LVL_FULL);
	assign rif.at_zero = (lvl_q == 8'h00);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			div_q <= '0;
		else if (tick || !(rif.up || rif.down))
			div_q <= '0;
		else
			div_q <= div_q + 32'h1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			lvl_q <= 8'h00;
		else if (rif.clear)
			lvl_q <= 8'h00;
		else if (tick && rif.up && lvl_q != `AMPC_LVL_FULL)
			lvl_q <= lvl_q + 8'h01;
		else if (tick && rif.down && lvl_q != 8'h00)
			lvl_q <= lvl_q - 8'h01;
	end
endmodule
`default_nettype wire

// file: ampc_top.sv
// Control and protection logic of a two-channel class-D amplifier.
// Assumes static host pins and digital fault flags from analog comparators.
`timescale 1ns/1ps
`default_nettype none
`include "ampc_map.svh"
module ampc_top
	import ampc_pkg::*;
#(
	parameter int RETRY_CYC = `AMPC_RETRY_CYC,
	parameter int RAMP_CYC  = `AMPC_RAMP_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	// Host control pins
	input  wire logic        gain_sel_lo_i,
	input  wire logic        gain_sel_hi_i,
	input  wire logic        mute_n_i,
	input  wire logic        powerdown_n_i,
	input  wire logic        master_slave_sel_i,
	input  wire logic        bridged_i,
	// Sampling clock pin and external clock
	input  wire logic        ext_clk_i,
	input  wire logic        int_osc_i,
	output logic             sampling_clock_pin_o,
	output logic             sampling_clock_pin_oe_n_o,
	output logic             sampling_clock_sel_o,
	// Fault flags from comparators
	input  wire logic        short_flag_i,
	input  wire logic        otemp_flag_i,
	input  wire logic        uvolt_flag_i,
	// Output stage control
	output logic             output_off_state_o,
	output logic [7:0]       mute_level_o,
	output logic [5:0]       gain_db_o,
	output logic             powered_o,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Interrupt
	output logic             irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Reset and synchronisers
	logic [1:0] rst_q;
	logic       rst_n;
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rst_q <= 2'b00;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	logic [8:0] pins_s;
	logic       g_lo, g_hi, mute_n, pd_n, ms_sel, btl, sh_f, ot_f, uv_f;
	ampc_sync #(.W(9)) u_sync (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n),
		.d_i     ({gain_sel_lo_i, gain_sel_hi_i, mute_n_i, powerdown_n_i,
		           master_slave_sel_i, bridged_i, short_flag_i, otemp_flag_i,
		           uvolt_flag_i}),
		.q_o     (pins_s)
	);
	assign {g_lo, g_hi, mute_n, pd_n, ms_sel, btl, sh_f, ot_f, uv_f} = pins_s;

	////////////////////////////////////////////////////////////////////////////////
	// Gain decode and clock mode
	logic [5:0] gain_se;
	always_comb begin
		case ({g_hi, g_lo})
			2'b00:   gain_se = `AMPC_GAIN_SE_0;
			2'b01:   gain_se = `AMPC_GAIN_SE_1;
			2'b10:   gain_se = `AMPC_GAIN_SE_2;
			default: gain_se = `AMPC_GAIN_SE_3;
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			gain_db_o <= `AMPC_GAIN_SE_0;
		else
			gain_db_o <= btl ? gain_se + `AMPC_GAIN_BTL_OFS : gain_se;
	end

	// master drives pin, slave takes it
	assign sampling_clock_sel_o      = ms_sel;
	assign sampling_clock_pin_o      = ms_sel ? 1'b0 : int_osc_i;
	assign sampling_clock_pin_oe_n_o = ms_sel;

	////////////////////////////////////////////////////////////////////////////////
	// External clock watch
	// The external clock only feeds the modulator, so the block watches its
	// edges; otherwise a slave whose clock stops would be silent to software.
	logic        ext_s;
	logic        ext_prev_q;
	logic [11:0] ext_idle_q;
	logic        ext_edge;
	logic        ext_alive;
	ampc_sync #(.W(1)) u_sync_ext (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n),
		.d_i     (ext_clk_i),
		.q_o     (ext_s)
	);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			ext_prev_q <= 1'b0;
		else
			ext_prev_q <= ext_s;
	end
	assign ext_edge = ext_s && !ext_prev_q;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			ext_idle_q <= `AMPC_EXT_IDLE_MAX;
		else if (ext_edge)
			ext_idle_q <= 12'h000;
		else if (ext_idle_q != `AMPC_EXT_IDLE_MAX)
			ext_idle_q <= ext_idle_q + 12'h001;
	end
	assign ext_alive = ms_sel && (ext_idle_q != `AMPC_EXT_IDLE_MAX);

	////////////////////////////////////////////////////////////////////////////////
	// Protection and sequencing
	ampc_ramp_if rif ();
	ampc_ramp #(.STEP_CYC(RAMP_CYC / 255)) u_ramp (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n),
		.rif     (rif)
	);

	// power-down low acts as reset of control state
	logic ctl_rst_n;
	assign ctl_rst_n = rst_n & pd_n;

	ampc_state_t st_q, st_d;
	logic [31:0] retry_q;
	logic        retry_tick;
	assign retry_tick = (retry_q == 32'(RETRY_CYC - 1));

	always_ff @(posedge sys_clk_i or negedge ctl_rst_n) begin
		if (!ctl_rst_n)
			retry_q <= '0;
		else if (st_q != ST_SHORT || retry_tick)
			retry_q <= '0;
		else
			retry_q <= retry_q + 32'h1;
	end

	logic mute_req;
	assign mute_req = !mute_n || ot_f || uv_f;

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_OFF:       st_d = ST_MUTED;
			ST_MUTED: begin
				if (!mute_req)
					st_d = ST_RAMP_UP;
			end
			ST_RAMP_UP: begin
				if (mute_req)
					st_d = ST_RAMP_DOWN;
				else if (rif.at_top)
					st_d = ST_RUN;
			end
			ST_RUN: begin
				// soft-mute on over-temperature, under-voltage or mute pin
				if (mute_req)
					st_d = ST_RAMP_DOWN;
			end
			ST_RAMP_DOWN: begin
				if (!mute_req)
					st_d = ST_RAMP_UP;
				else if (rif.at_zero)
					st_d = ST_MUTED;
			end
			ST_SHORT: begin
				if (retry_tick && !sh_f)
					st_d = ST_MUTED;
			end
			default:      st_d = ST_OFF;
		endcase
		if (sh_f && st_q != ST_OFF)
			st_d = ST_SHORT;
	end

	// pd low resets directly, no ramp
	always_ff @(posedge sys_clk_i or negedge ctl_rst_n) begin
		if (!ctl_rst_n)
			st_q <= ST_OFF;
		else
			st_q <= st_d;
	end

	assign rif.up    = (st_q == ST_RAMP_UP);
	assign rif.down  = (st_q == ST_RAMP_DOWN);
	assign rif.clear = !pd_n || st_q == ST_SHORT || st_q == ST_OFF;

	// level drops in the cycle the outputs go off
	logic out_off_d;
	assign out_off_d = !pd_n || st_d == ST_SHORT || st_q == ST_OFF;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			output_off_state_o <= 1'b1;
			mute_level_o       <= 8'h00;
			powered_o          <= 1'b0;
		end else begin
			output_off_state_o <= out_off_d;
			mute_level_o       <= out_off_d ? 8'h00 : rif.level;
			powered_o          <= pd_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers: 0x0 status, 0x4 irq status (w1c), 0x8 irq mask, 0xc spare bit
	logic [`AMPC_IRQ_W-1:0] ists_q, imask_q, ev, f_q;
	logic                   fmute_q;
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n)
			f_q <= '0;
		else
			f_q <= {uv_f, ot_f, sh_f};
	end
	assign ev = {uv_f, ot_f, sh_f} & ~f_q;

	logic aw_q, w_q;
	logic [3:0]  awa_q;
	logic [31:0] wd_q;
	logic        wr_go;
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign wr_go         = aw_q && w_q;
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 4'h0;
			wd_q <= 32'h0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q  <= 1'b1;
				awa_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q  <= 1'b1;
				wd_q <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_bresp = 2'b00;

	logic w1c;
	assign w1c = wr_go && awa_q == 4'h4;
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ists_q  <= '0;
			imask_q <= '0;
			fmute_q <= 1'b0;
		end else begin
			// Set wins over a simultaneous clear
			ists_q <= (ists_q & ~(w1c ? wd_q[`AMPC_IRQ_W-1:0] : '0)) | ev;
			if (wr_go && awa_q == 4'h8)
				imask_q <= wd_q[`AMPC_IRQ_W-1:0];
			if (wr_go && awa_q == 4'hc)
				fmute_q <= wd_q[0];
		end
	end
	assign irq_o = |(ists_q & imask_q);

	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp   = 2'b00;
	// Status: external clock seen, power, select, short latch, level
	logic [31:0] status_word;
	assign status_word = {20'h0, ext_alive, pd_n, ms_sel, st_q == ST_SHORT, rif.level};
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
				4'h0:    s_axi_rdata <= status_word;
				4'h4:    s_axi_rdata <= {29'h0, ists_q};
				4'h8:    s_axi_rdata <= {29'h0, imask_q};
				4'hc:    s_axi_rdata <= {31'h0, fmute_q};
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	logic unused_ok;
	assign unused_ok = ^{s_axi_wstrb, fmute_q};
endmodule
`default_nettype wire

// file: ampc_checker.sv
// Port assertions for the amplifier control and protection block.
// Assumes a bind to ampc_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ampc_checker (
	// Clock, reset and pins
	input  wire logic       sys_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       gain_sel_lo_i,
	input  wire logic       gain_sel_hi_i,
	input  wire logic       bridged_i,
	input  wire logic       mute_n_i,
	input  wire logic       powerdown_n_i,
	input  wire logic       master_slave_sel_i,
	input  wire logic       int_osc_i,
	input  wire logic       short_flag_i,
	input  wire logic       otemp_flag_i,
	input  wire logic       uvolt_flag_i,
	// Outputs watched
	input  wire logic       sampling_clock_pin_o,
	input  wire logic       sampling_clock_pin_oe_n_o,
	input  wire logic       output_off_state_o,
	input  wire logic [7:0] mute_level_o,
	input  wire logic [5:0] gain_db_o,
	input  wire logic       powered_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [5:0] gain_exp;
	assign gain_exp = 6'h0e + 6'h06 * {4'h0, gain_sel_hi_i, gain_sel_lo_i}
		+ (bridged_i ? 6'h06 : 6'h00);
	// Pins must settle past the synchronisers before the decode is judged
	sequence pins_still;
		($stable({gain_sel_hi_i, gain_sel_lo_i, bridged_i}) && powerdown_n_i) [*6];
	endsequence
	sequence faulted;
		(otemp_flag_i || uvolt_flag_i) [*8];
	endsequence
	gain_map_a: assert property (pins_still |-> gain_db_o == gain_exp)
		else $error("gain does not match pins");
	pd_off_a: assert property (!powered_o |-> output_off_state_o)
		else $error("outputs on while powered down");
	pd_fast_a: assert property ($fell(powerdown_n_i) |-> ##[0:5] !powered_o)
		else $error("power-down not taken");
	off_zero_a: assert property (output_off_state_o |-> mute_level_o == 8'h00)
		else $error("level kept with outputs off");
	short_off_a: assert property (short_flag_i && powered_o |-> ##[1:5] output_off_state_o)
		else $error("short did not turn outputs off");
	mute_down_a: assert property (!mute_n_i [*8] |-> mute_level_o <= $past(mute_level_o))
		else $error("level rose while muted");
	fault_down_a: assert property (faulted |-> mute_level_o <= $past(mute_level_o))
		else $error("level rose during fault");
	master_clk_a: assert property (!master_slave_sel_i [*8]
		|-> !sampling_clock_pin_oe_n_o && sampling_clock_pin_o == int_osc_i)
		else $error("master clock pin wrong");
	slave_clk_a: assert property ((master_slave_sel_i && powerdown_n_i) [*8]
		|-> sampling_clock_pin_oe_n_o && !sampling_clock_pin_o)
		else $error("slave clock pin driven");
endmodule
`default_nettype wire

// file: ampc_host.sv
// Host controller model driving the static control pins.
// Assumes bench requests change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ampc_host (
	// Clock and requests
	input  wire logic clk_i,
	input  wire logic pd_req_i,
	input  wire logic mute_req_i,
	input  wire logic slave_req_i,
	// Pins
	output logic      powerdown_n_o = 1'h0,
	output logic      mute_n_o = 1'h0,
	output logic      master_slave_sel_o = 1'h0,
	output logic      ext_clk_o = 1'h0
);
	// mute follows power-down, never high while it is low
	always @(posedge clk_i) begin
		powerdown_n_o <= pd_req_i;
		mute_n_o <= mute_req_i && pd_req_i && powerdown_n_o;
	end
	// half-duty clock only in slave mode
	always @(posedge clk_i) begin
		master_slave_sel_o <= slave_req_i;
		ext_clk_o <= slave_req_i && !ext_clk_o;
	end
endmodule
`default_nettype wire

// file: ampc_top_tb.sv
// Bench for the amplifier control block: pins, faults and registers.
// Assumes shortened ramp and retry counts given at the instance.
`timescale 1ns/1ps
`default_nettype none
module ampc_top_tb;
	logic clk = 1'b0, rst_n = 1'b0, pd = 1'b1, mu = 1'b1, sl = 1'b0, glo = 1'b0, ghi = 1'b0;
	logic btl = 1'b0, osc = 1'b0, sh = 1'b0, ot = 1'b0, uv = 1'b0, awv = 1'b0, wv = 1'b0;
	logic bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [3:0] aw = 4'h0, ar = 4'h0;
	logic [31:0] wd = 32'h0;
	wire logic [1:0] brs, rrs;
	wire logic pdn, mun, mss, ext, scp, scoe, scs, awr, wr, bv, arr, rv, irq, off, pwr;
	wire logic [7:0] lvl;
	wire logic [5:0] gdb;
	wire logic [31:0] rdat;
	int num_errors = 0, n_tests = 0;
	always #2 clk = ~clk;
	always @(posedge clk) osc <= ~osc;
	ampc_host u_ampc_host (.clk_i(clk), .pd_req_i(pd), .mute_req_i(mu), .slave_req_i(sl),
		.powerdown_n_o(pdn), .mute_n_o(mun), .master_slave_sel_o(mss), .ext_clk_o(ext));
	ampc_top #(.RETRY_CYC(50), .RAMP_CYC(255)) u_ampc_top (.sys_clk_i(clk), .reset_n_i(rst_n),
		.gain_sel_lo_i(glo), .gain_sel_hi_i(ghi), .mute_n_i(mun), .powerdown_n_i(pdn),
		.master_slave_sel_i(mss), .bridged_i(btl), .ext_clk_i(ext), .int_osc_i(osc),
		.sampling_clock_pin_o(scp), .sampling_clock_pin_oe_n_o(scoe),
		.sampling_clock_sel_o(scs), .short_flag_i(sh), .otemp_flag_i(ot), .uvolt_flag_i(uv),
		.output_off_state_o(off), .mute_level_o(lvl), .gain_db_o(gdb), .powered_o(pwr),
		.s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(brs),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
		.s_axi_rready(rre), .irq_o(irq));
	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tmo(bit t);
		if (t) begin
			$display("MISMATCH wait exp answer got timeout");
			num_errors++;
			report_and_stop();
		end
	endtask
	// Ramps take about 255 cycles, retries 50: 2000 leaves margin
	task automatic wait_lvl(logic [7:0] v);
		int i;
		n_tests++;
		for (i = 0; i < 2000 && lvl !== v; i++) @(negedge clk);
		tmo(i == 2000);
	endtask
	task automatic axi_wr(logic [3:0] a, logic [31:0] d);
		int i;
		@(posedge clk);
		aw <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
			if (bv) break;
		end
		bre <= 0;
		tmo(i == 50);
		chk("bresp", 0, brs);
	endtask
	task automatic rd_chk(logic [3:0] a, logic [31:0] e);
		int i;
		@(posedge clk);
		ar <= a; arv <= 1; rre <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arr) arv <= 0;
			if (rv) break;
		end
		rre <= 0;
		tmo(i == 50);
		chk("rdata", e, rdat);
		chk("rresp", 0, rrs);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		wait_lvl(8'hff);
		chk("off", 0, off);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk) {btl, ghi, glo} <= k[2:0];
			repeat (8) @(negedge clk);
			chk("gain", 6'h0e + 6'h06 * k[1:0] + 6'h06 * k[2], gdb);
		end
		@(posedge clk) sl <= 1;
		repeat (8) @(negedge clk);
		chk("oe_n", 1, scoe);
		chk("sel", 1, scs);
		rd_chk(4'h0, 32'h0000_0eff);
		@(posedge clk) sl <= 0;
		repeat (8) @(negedge clk);
		chk("oe_n", 0, scoe);
		chk("pin", osc, scp);
		@(posedge clk) mu <= 0;
		wait_lvl(0);
		chk("off", 0, off);
		@(posedge clk) pd <= 0;
		repeat (6) @(negedge clk);
		chk("pd", 2'h2, {off, pwr});
		@(posedge clk) {pd, mu} <= 2'h3;
		wait_lvl(8'hff);
		@(posedge clk) pd <= 0;
		repeat (6) @(negedge clk);
		chk("direct", 10'h200, {off, pwr, lvl});
		@(posedge clk) pd <= 1;
		wait_lvl(8'hff);
		for (int f = 0; f < 3; f++) begin
			@(posedge clk) {uv, ot, sh} <= 3'h1 << f;
			if (f == 0) begin
				repeat (150) @(negedge clk);
				chk("short", 1, off);
			end
			wait_lvl(0);
			@(posedge clk) {uv, ot, sh} <= 3'h0;
			wait_lvl(8'hff);
		end
		chk("irq", 0, irq);
		rd_chk(4'h4, 32'h7);
		axi_wr(4'h8, 32'h5);
		repeat (2) @(negedge clk);
		chk("irq", 1, irq);
		axi_wr(4'h4, 32'h5);
		repeat (2) @(negedge clk);
		chk("irq", 0, irq);
		rd_chk(4'h4, 32'h2);
		rd_chk(4'h0, 32'h4ff);
		report_and_stop();
	end
endmodule
bind ampc_top ampc_checker u_ampc_checker (.sys_clk_i, .reset_n_i, .gain_sel_lo_i,
	.gain_sel_hi_i, .bridged_i, .mute_n_i, .powerdown_n_i, .master_slave_sel_i, .int_osc_i,
	.short_flag_i, .otemp_flag_i, .uvolt_flag_i, .sampling_clock_pin_o,
	.sampling_clock_pin_oe_n_o, .output_off_state_o, .mute_level_o, .gain_db_o, .powered_o);
`default_nettype wire
